/* rtl/kalv_defs.svh */
// Field widths, positions, codes and timing constants of the keep-alive message.
// Assumes inclusion by the package and the framer only.
`ifndef KALV_DEFS_SVH
`define KALV_DEFS_SVH
`define KALV_HDR_W 32
`define KALV_ACK_W 16
`define KALV_REC_W 8
`define KALV_HDR_R_POS 31
`define KALV_HDR_RTL_POS 27
`define KALV_HDR_TIME_POS 24
`define KALV_HDR_MINL_POS 18
`define KALV_HDR_SEQ_POS 13
`define KALV_ACK_R_POS 15
`define KALV_ACK_ENC_POS 8
`define KALV_ACK_SNR_POS 4
`define KALV_ACK_POW_POS 0
`define KALV_REP_MAX_EXACT 3'h5
`define KALV_REP_SIX_PLUS 3'h6
`define KALV_REP_EXHAUSTED 3'h7
`define KALV_UNREG_SEC_0 16'h0080
`define KALV_UNREG_SEC_1 16'h0100
`define KALV_UNREG_SEC_2 16'h0200
`define KALV_UNREG_SEC_3 16'h0800
`define KALV_UNREG_SEC_4 16'h1000
`define KALV_UNREG_SEC_5 16'h2000
`define KALV_UNREG_SEC_6 16'h4000
`define KALV_UNREG_SEC_7 16'h8000
`define KALV_TICK_NS 32'd1000000000
`define KALV_CLK_NS 32'd8
`define KALV_TICK_CYCLES (`KALV_TICK_NS / `KALV_CLK_NS)
`endif

/* rtl/kalv_pkg.sv */
// Types shared by the keep-alive field framer.
// Assumes kalv_defs.svh is on the include path.
`include "kalv_defs.svh"
package kalv_pkg;
  typedef struct packed {
    logic req_resp_flag;
    logic [3:0] path_retries_left;
    logic [2:0] unregister_timeout_code;
    logic [5:0] min_record_level;
    logic [2:0] tx_sequence_count;
  } kalv_hdr_s;
  typedef struct packed {
    logic down_record_valid;
    logic [2:0] down_hop_repeats;
    logic up_record_valid;
    logic [2:0] up_hop_repeats;
  } kalv_rec_s;
  typedef struct packed {
    logic [3:0] rx_encoding_report;
    logic [3:0] rx_snr_report;
    logic [3:0] rx_power_report;
  } kalv_rep_s;
  typedef enum logic [0:0] {KALV_DOWN, KALV_UP} kalv_dir_e;
endpackage : kalv_pkg

/* rtl/kalv_framer.sv */
// Keep-alive control message field builder and parser for one node.
// Assumes synchronous inputs on core_clk and a MAC that serialises the words.
//
// Overview of operation
// - Flag one in request/response, zero in acks.
// - Four-bit count of repetitions left on path.
// - Three-bit code selects unregister timeout seconds.
// - Six-bit minimum level for own records.
// - Downlink: level+1 <= min sums into record zero.
// - Uplink: level below min sums into record zero.
// - Sequence count zeroed per hop, bumped per repetition.
// - Downlink valid flag; invalid records discarded.
// - Repeat code 0-5 exact, 6 many, 7 exhausted.
// - Uplink valid flag marks usable record.
// - Base request carries previous uplink repeat counts.
// - Acks report receive SNR and power nibbles.
`include "kalv_defs.svh"
module kalv_framer
  import kalv_pkg::*;
#(
  parameter int NREC = 8,
  parameter int TICK_CYCLES = `KALV_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hop_start,
  input wire logic hop_repeat,
  input wire logic ack_seen,
  input wire kalv_hdr_s tx_hdr_in,
  input wire kalv_rep_s tx_rep_in,
  input wire logic [NREC*`KALV_REC_W-1:0] tx_recs_in,
  input wire logic [5:0] node_level,
  input wire kalv_dir_e merge_dir,
  input wire logic [2:0] own_repeats,
  input wire logic [$clog2(NREC)-1:0] append_index,
  input wire logic merge_go,
  input wire logic base_fill,
  input wire logic [NREC*3-1:0] prev_up_repeats,
  input wire logic timeout_restart,
  input wire logic [`KALV_HDR_W-1:0] rx_hdr_word,
  input wire logic [`KALV_ACK_W-1:0] rx_ack_word,
  input wire logic [NREC*`KALV_REC_W-1:0] rx_recs_word,
  input wire logic rx_load,
  output logic [`KALV_HDR_W-1:0] tx_req_word,
  output logic [`KALV_ACK_W-1:0] tx_ack_word,
  output logic [NREC*`KALV_REC_W-1:0] tx_recs_out,
  output logic merged_into_first,
  output logic [2:0] tx_sequence_count,
  output kalv_hdr_s rx_hdr,
  output kalv_rep_s rx_rep,
  output logic rx_is_ack,
  output logic [NREC-1:0] rx_down_use,
  output logic [NREC-1:0] rx_up_use,
  output logic [NREC*3-1:0] rx_down_repeats,
  output logic [NREC*3-1:0] rx_up_repeats,
  output logic unregistered
);

  ////////////////////////////////////////////////////////////////////////////
  // Sequence counter
  logic [2:0] seq_r;
  logic seq_run_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_r <= 3'h0;
      seq_run_r <= 1'b0;
    end else if (hop_start) begin
      seq_r <= 3'h0;
      seq_run_r <= 1'b1;
    end else if (ack_seen) begin
      seq_run_r <= 1'b0;
    end else if (hop_repeat && seq_run_r) begin
      seq_r <= seq_r + 3'h1;
    end
  end
  assign tx_sequence_count = seq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit words, MSB first with reserved bits zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_req_word <= '0;
      tx_ack_word <= '0;
    end else begin
      tx_req_word <= '0;
      tx_req_word[`KALV_HDR_R_POS] <= 1'b1;
      tx_req_word[`KALV_HDR_RTL_POS +: 4] <= tx_hdr_in.path_retries_left;
      tx_req_word[`KALV_HDR_TIME_POS +: 3] <= tx_hdr_in.unregister_timeout_code;
      tx_req_word[`KALV_HDR_MINL_POS +: 6] <= tx_hdr_in.min_record_level;
      tx_req_word[`KALV_HDR_SEQ_POS +: 3] <= seq_r;
      tx_ack_word <= '0;
      tx_ack_word[`KALV_ACK_R_POS] <= 1'b0;
      tx_ack_word[`KALV_ACK_ENC_POS +: 4] <= tx_rep_in.rx_encoding_report;
      tx_ack_word[`KALV_ACK_SNR_POS +: 4] <= tx_rep_in.rx_snr_report;
      tx_ack_word[`KALV_ACK_POW_POS +: 4] <= tx_rep_in.rx_power_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Record merge: sum into record zero or append own record
  logic merge_first;
  always_comb begin
    if (merge_dir == KALV_DOWN) begin
      merge_first = ({1'b0, node_level} + 7'h01) <= {1'b0, tx_hdr_in.min_record_level};
    end else begin
      merge_first = node_level < tx_hdr_in.min_record_level;
    end
  end

  // Saturating sum: an exhausted hop stays 7, otherwise the sum caps at 6
  function automatic logic [2:0] kalv_sum(input logic [2:0] a, input logic [2:0] b);
    logic [3:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (a == `KALV_REP_EXHAUSTED || b == `KALV_REP_EXHAUSTED) begin
      kalv_sum = `KALV_REP_EXHAUSTED;
    end else if (s > {1'b0, `KALV_REP_MAX_EXACT}) begin
      kalv_sum = `KALV_REP_SIX_PLUS;
    end else begin
      kalv_sum = s[2:0];
    end
  endfunction : kalv_sum

  genvar gi;
  generate
    for (gi = 0; gi < NREC; gi++) begin : g_rec
      kalv_rec_s rin;
      kalv_rec_s rcv;
      assign rin = tx_recs_in[gi*`KALV_REC_W +: `KALV_REC_W];
      assign rcv = rx_recs_word[gi*`KALV_REC_W +: `KALV_REC_W];
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          tx_recs_out[gi*`KALV_REC_W +: `KALV_REC_W] <= '0;
        end else if (base_fill) begin
          tx_recs_out[gi*`KALV_REC_W +: `KALV_REC_W] <= {rin.down_record_valid,
            rin.down_hop_repeats, 1'b1, prev_up_repeats[gi*3 +: 3]};
        end else if (merge_go && merge_first && gi == 0) begin
          if (merge_dir == KALV_DOWN) begin
            tx_recs_out[gi*`KALV_REC_W +: `KALV_REC_W] <= {1'b1,
              kalv_sum(rin.down_hop_repeats, own_repeats), rin.up_record_valid,
              rin.up_hop_repeats};
          end else begin
            tx_recs_out[gi*`KALV_REC_W +: `KALV_REC_W] <= {rin.down_record_valid,
              rin.down_hop_repeats, 1'b1, kalv_sum(rin.up_hop_repeats, own_repeats)};
          end
        end else if (merge_go && !merge_first && gi == int'(append_index)) begin
          if (merge_dir == KALV_DOWN) begin
            tx_recs_out[gi*`KALV_REC_W +: `KALV_REC_W] <= {1'b1, own_repeats,
              rin.up_record_valid, rin.up_hop_repeats};
          end else begin
            tx_recs_out[gi*`KALV_REC_W +: `KALV_REC_W] <= {rin.down_record_valid,
              rin.down_hop_repeats, 1'b1, own_repeats};
          end
        end else if (merge_go) begin
          tx_recs_out[gi*`KALV_REC_W +: `KALV_REC_W] <= rin;
        end
      end
      // Receive side: repeats of a record whose flag is clear read as zero
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          rx_down_use[gi] <= 1'b0;
          rx_up_use[gi] <= 1'b0;
          rx_down_repeats[gi*3 +: 3] <= 3'h0;
          rx_up_repeats[gi*3 +: 3] <= 3'h0;
        end else if (rx_load) begin
          rx_down_use[gi] <= rcv.down_record_valid;
          rx_up_use[gi] <= rcv.up_record_valid;
          rx_down_repeats[gi*3 +: 3] <= rcv.down_record_valid ? rcv.down_hop_repeats : 3'h0;
          rx_up_repeats[gi*3 +: 3] <= rcv.up_record_valid ? rcv.up_hop_repeats : 3'h0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      merged_into_first <= 1'b0;
    end else if (merge_go) begin
      merged_into_first <= merge_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive header parse; reserved bits are never looked at
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_hdr <= '0;
      rx_rep <= '0;
      rx_is_ack <= 1'b0;
    end else if (rx_load) begin
      rx_hdr.req_resp_flag <= rx_hdr_word[`KALV_HDR_R_POS];
      rx_hdr.path_retries_left <= rx_hdr_word[`KALV_HDR_RTL_POS +: 4];
      rx_hdr.unregister_timeout_code <= rx_hdr_word[`KALV_HDR_TIME_POS +: 3];
      rx_hdr.min_record_level <= rx_hdr_word[`KALV_HDR_MINL_POS +: 6];
      rx_hdr.tx_sequence_count <= rx_hdr_word[`KALV_HDR_SEQ_POS +: 3];
      rx_is_ack <= !rx_ack_word[`KALV_ACK_R_POS];
      rx_rep.rx_encoding_report <= rx_ack_word[`KALV_ACK_ENC_POS +: 4];
      rx_rep.rx_snr_report <= rx_ack_word[`KALV_ACK_SNR_POS +: 4];
      rx_rep.rx_power_report <= rx_ack_word[`KALV_ACK_POW_POS +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unregister timer; seconds come from counting TICK_CYCLES core_clk cycles
  logic [31:0] tick_cnt_r;
  logic [15:0] sec_cnt_r;
  logic [15:0] limit_sec;
  always_comb begin
    unique case (tx_hdr_in.unregister_timeout_code)
      3'h0: limit_sec = `KALV_UNREG_SEC_0;
      3'h1: limit_sec = `KALV_UNREG_SEC_1;
      3'h2: limit_sec = `KALV_UNREG_SEC_2;
      3'h3: limit_sec = `KALV_UNREG_SEC_3;
      3'h4: limit_sec = `KALV_UNREG_SEC_4;
      3'h5: limit_sec = `KALV_UNREG_SEC_5;
      3'h6: limit_sec = `KALV_UNREG_SEC_6;
      3'h7: limit_sec = `KALV_UNREG_SEC_7;
    endcase
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= 32'h0;
      sec_cnt_r <= 16'h0;
      unregistered <= 1'b0;
    end else if (timeout_restart) begin
      tick_cnt_r <= 32'h0;
      sec_cnt_r <= 16'h0;
      unregistered <= 1'b0;
    end else if (!unregistered) begin
      if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_r <= 32'h0;
        sec_cnt_r <= sec_cnt_r + 16'h1;
        // At-or-above so a code lowered mid-count still expires promptly
        if (sec_cnt_r + 16'h1 >= limit_sec) begin
          unregistered <= 1'b1;
        end
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
      end
    end
  end

endmodule : kalv_framer

/* tb/kalv_framer_properties.sv */
// Checker: port timing of the keep-alive framer.
// Assumes one clock domain and an asynchronous active-low reset.
module kalv_framer_properties
  import kalv_pkg::*;
#(parameter int NREC = 8, parameter int TICK_CYCLES = 4) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hop_start,
  input wire logic hop_repeat,
  input wire logic ack_seen,
  input wire kalv_hdr_s tx_hdr_in,
  input wire kalv_rep_s tx_rep_in,
  input wire logic [5:0] node_level,
  input wire kalv_dir_e merge_dir,
  input wire logic merge_go,
  input wire logic base_fill,
  input wire logic [15:0] rx_ack_word,
  input wire logic [NREC*8-1:0] rx_recs_word,
  input wire logic rx_load,
  input wire logic [31:0] tx_req_word,
  input wire logic [15:0] tx_ack_word,
  input wire logic merged_into_first,
  input wire logic [2:0] tx_sequence_count,
  input wire logic rx_is_ack,
  input wire logic [NREC*3-1:0] rx_down_repeats
);
  // Widened sum so level 63 cannot wrap into a merge
  logic to_first;
  always_comb to_first = merge_dir == KALV_UP ? node_level < tx_hdr_in.min_record_level
    : 7'(node_level) + 7'h01 <= 7'(tx_hdr_in.min_record_level);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_start_rep;
    hop_start ##1 (hop_repeat && !hop_start && !ack_seen);
  endsequence
  sequence s_ack_quiet;
    (ack_seen && !hop_start) ##1 !hop_start;
  endsequence
  ////////////////////////////////////////
  a_req_fields: assert property ($past(reset_n, 2) |->
    tx_req_word[31] && tx_req_word[30:18] == $past(tx_hdr_in[15:3])) else $error("req fields");
  a_req_reserved: assert property (tx_req_word[17:16] == 2'h0 &&
    tx_req_word[12:0] == 13'h0000) else $error("req reserved");
  a_ack_fields: assert property ($past(reset_n, 2) |->
    tx_ack_word == {4'h0, $past(tx_rep_in)}) else $error("ack fields");
  a_seq_zero: assert property (hop_start |=> tx_sequence_count == 3'h0)
    else $error("seq not zeroed");
  a_seq_step: assert property (s_start_rep |=> tx_sequence_count == 3'h1)
    else $error("seq not stepped");
  a_seq_hold: assert property (s_ack_quiet |=> $stable(tx_sequence_count))
    else $error("seq moved after ack");
  a_rx_flag: assert property (rx_load |=> rx_is_ack == !$past(rx_ack_word[15]))
    else $error("rx ack flag");
  a_rx_discard: assert property (rx_load |=> rx_down_repeats[2:0] ==
    ($past(rx_recs_word[7]) ? $past(rx_recs_word[6:4]) : 3'h0)) else $error("rx discard");
  a_merge_pick: assert property (merge_go && !base_fill |=>
    merged_into_first == $past(to_first)) else $error("merge pick");
endmodule : kalv_framer_properties
bind kalv_framer kalv_framer_properties #(.NREC(NREC), .TICK_CYCLES(TICK_CYCLES)) u_props (.*);

/* tb/kalv_peer_model.sv */
// Peer node: frames keep-alive words towards the framer.
// Assumes send is a one-cycle pulse; words are scrambled between frames.
module kalv_peer_model (
  input wire logic core_clk,
  input wire logic send,
  input wire logic as_ack,
  input wire logic [11:0] peer_rep,
  input wire logic [31:0] peer_hdr,
  input wire logic [63:0] peer_recs,
  output logic [31:0] rx_hdr_word = 32'h0,
  output logic [15:0] rx_ack_word = 16'h0,
  output logic [63:0] rx_recs_word = 64'h0,
  output logic rx_load = 1'h0
);
  ////////////////////////////////////////
  always @(posedge core_clk) begin
    rx_load <= send;
    if (send) begin
      rx_ack_word <= {~as_ack, 3'h0, peer_rep};
      rx_hdr_word <= peer_hdr;
      rx_recs_word <= peer_recs;
    end else begin
      rx_ack_word <= ~rx_ack_word;
      rx_hdr_word <= ~rx_hdr_word;
      rx_recs_word <= ~rx_recs_word;
    end
  end
endmodule : kalv_peer_model

/* tb/test_keep_alive_control_packet_fields.sv */
// Bench for the keep-alive framer with a peer model.
// Assumes a one-second tick shortened to 4 cycles.
module test_keep_alive_control_packet_fields
  import kalv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, reset_n = 1'h0, hop_start = 1'h0, hop_repeat = 1'h0, ack_seen = 1'h0;
  logic merge_go = 1'h0, base_fill = 1'h0, timeout_restart = 1'h0, send = 1'h0, as_ack = 1'h0;
  kalv_hdr_s tx_hdr_in = '0, rx_hdr;
  kalv_rep_s tx_rep_in = '0, rx_rep;
  kalv_dir_e merge_dir = KALV_DOWN;
  logic [5:0] node_level = 6'h0;
  logic [2:0] own_repeats = 3'h0, append_index = 3'h2, tx_sequence_count;
  logic [23:0] prev_up_repeats = 24'h00003D, rx_down_repeats, rx_up_repeats;
  logic [63:0] tx_recs_in = 64'h1111111111001132, peer_recs = 64'hE75B, rx_recs_word, tx_recs_out;
  logic [31:0] rx_hdr_word, tx_req_word;
  logic [15:0] rx_ack_word, tx_ack_word;
  logic [11:0] peer_rep = 12'h59A;
  // Reserved bits set on purpose: the parser must ignore them
  logic [31:0] peer_hdr = 32'hD557DFFF;
  logic [7:0] rx_down_use, rx_up_use;
  logic rx_load, merged_into_first, rx_is_ack, unregistered;
  int err_total = 0, compares = 0, cyc = 0;
  kalv_framer #(.NREC(8), .TICK_CYCLES(4)) dut (.core_clk, .reset_n, .hop_start, .hop_repeat,
    .ack_seen, .tx_hdr_in, .tx_rep_in, .tx_recs_in, .node_level, .merge_dir, .own_repeats,
    .append_index, .merge_go, .base_fill, .prev_up_repeats, .timeout_restart, .rx_hdr_word,
    .rx_ack_word, .rx_recs_word, .rx_load, .tx_req_word, .tx_ack_word, .tx_recs_out,
    .merged_into_first, .tx_sequence_count, .rx_hdr, .rx_rep, .rx_is_ack, .rx_down_use,
    .rx_up_use, .rx_down_repeats, .rx_up_repeats, .unregistered);
  kalv_peer_model peer (.core_clk, .send, .as_ack, .peer_rep, .peer_hdr, .peer_recs,
    .rx_hdr_word, .rx_ack_word, .rx_recs_word, .rx_load);
  ////////////////////////////////////////
  initial forever #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic merge_case(input kalv_dir_e d, input logic [5:0] lv, input logic [5:0] mn,
      input logic [2:0] own, input logic m, input logic [7:0] b0, input logic [7:0] b2);
    merge_dir = d;
    node_level = lv;
    tx_hdr_in.min_record_level = mn;
    own_repeats = own;
    merge_go = 1'h1;
    step(1);
    merge_go = 1'h0;
    step(1);
    chk("merged", m, merged_into_first);
    chk("rec0", b0, tx_recs_out[7:0]);
    chk("rec2", b2, tx_recs_out[23:16]);
  endtask : merge_case
  task automatic sc_header;
    for (int i = 0; i < 8; i++) begin
      tx_hdr_in = {1'h0, 4'(15 - i), 3'(i), 6'h2A, 3'h0};
      tx_rep_in = {4'h1, 4'(i), 4'(~i)};
      step(2);
      chk("req", {1'h1, 4'(15 - i), 3'(i), 6'h2A, 18'h00000}, tx_req_word);
      chk("ack", {4'h0, 4'h1, 4'(i), 4'(~i)}, tx_ack_word);
    end
  endtask : sc_header
  task automatic sc_seq;
    hop_start = 1'h1;
    step(1);
    hop_start = 1'h0;
    hop_repeat = 1'h1;
    step(3);
    ack_seen = 1'h1;
    step(1);
    ack_seen = 1'h0;
    step(2);
    chk("seq after ack", 3'h3, tx_sequence_count);
    chk("req seq field", 3'h3, tx_req_word[15:13]);
    hop_start = 1'h1;
    ack_seen = 1'h1;
    step(1);
    hop_start = 1'h0;
    ack_seen = 1'h0;
    step(2);
    hop_repeat = 1'h0;
    chk("seq restart", 3'h2, tx_sequence_count);
  endtask : sc_seq
  task automatic sc_rx;
    for (int k = 0; k < 2; k++) begin
      as_ack = k == 0;
      send = 1'h1;
      step(1);
      send = 1'h0;
      step(2);
      chk("rx ack", k == 0, rx_is_ack);
      chk("rx use", 4'h6, {rx_up_use[1:0], rx_down_use[1:0]});
      chk("rx reps", 12'h0F0, {rx_up_repeats[5:0], rx_down_repeats[5:0]});
      chk("rx hdr", {1'h1, 4'hA, 3'h5, 6'h15, 3'h6}, rx_hdr);
      chk("rx rep", 12'h59A, rx_rep);
    end
  endtask : sc_rx
  task automatic sc_timeout;
    // Codes 0 to 2 are 128, 256 and 512 seconds; a second is 4 cycles here
    for (int c = 0; c < 3; c++) begin
      tx_hdr_in.unregister_timeout_code = 3'(c);
      timeout_restart = 1'h1;
      step(1);
      timeout_restart = 1'h0;
      step((128 << c) * 4 - 1);
      chk("early unreg", 1'h0, unregistered);
      step(1);
      chk("unreg", 1'h1, unregistered);
    end
  endtask : sc_timeout
  task automatic report_and_stop;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    step(10);
    reset_n = 1'h1;
    step(2);
    sc_header();
    sc_seq();
    merge_case(KALV_DOWN, 6'h3, 6'h4, 3'h2, 1'h1, 8'hD2, 8'h00);
    merge_case(KALV_DOWN, 6'h4, 6'h4, 3'h4, 1'h0, 8'h32, 8'hC0);
    merge_case(KALV_UP, 6'h3, 6'h4, 3'h4, 1'h1, 8'h3E, 8'h00);
    merge_case(KALV_UP, 6'h4, 6'h4, 3'h7, 1'h0, 8'h32, 8'h0F);
    merge_case(KALV_DOWN, 6'h0, 6'h1, 3'h7, 1'h1, 8'hF2, 8'h00);
    base_fill = 1'h1;
    merge_go = 1'h1;
    step(1);
    base_fill = 1'h0;
    merge_go = 1'h0;
    step(1);
    chk("base fill", 24'h081F3D, tx_recs_out[23:0]);
    sc_rx();
    sc_timeout();
    report_and_stop();
  end
endmodule : test_keep_alive_control_packet_fields
